// ===== pkg/rtor_pkg.sv
// rtor_pkg: offsets, fields, reset values and carriers of the radio test override bank
package rtor_pkg;
   // register offsets on the serial register port
   localparam logic [6:0] OFF_SYN_TEST = 7'h5c;
   localparam logic [6:0] OFF_FORCE_A = 7'h5d;
   localparam logic [6:0] OFF_FORCE_B = 7'h5e;
   localparam logic [6:0] OFF_FORCE_SYN = 7'h5f;
   localparam logic [6:0] OFF_COEF_IDX = 7'h60;
   localparam logic [6:0] OFF_COEF_VAL = 7'h61;
   localparam logic [6:0] OFF_XTAL_CTL = 7'h62;
   // reset values of the writable bits
   localparam logic [7:0] RST_SYN_TEST = 8'h0e;
   localparam logic [7:0] RST_FORCE_A = 8'h00;
   localparam logic [7:0] RST_FORCE_B = 8'h00;
   localparam logic [7:0] RST_FORCE_SYN = 8'h00;
   localparam logic [3:0] RST_COEF_IDX = 4'h0;
   localparam logic [5:0] RST_COEF_VAL = 6'h00;
   localparam logic [4:0] RST_XTAL_CTL = 5'h04;
   // synthesizer test fields
   localparam int SYN_DITHER = 7;
   localparam int SYN_VCO_TYPE = 6;
   localparam int SYN_OPEN_LOOP = 5;
   localparam int SYN_MODULUS = 4;
   localparam int SYN_ORDER_LO = 2;
   localparam int SYN_RST_MODE = 1;
   localparam int SYN_RST = 0;
   // second override register fields
   localparam int FB_LOCK_DET = 6;
   localparam int FB_PLL_RST = 0;
   // oscillator control fields
   localparam int XC_PWST_LO = 5;
   localparam int XC_HYST = 4;
   localparam int XC_DOUBLE_BIAS = 3;
   localparam int XC_DOUBLE_GAIN = 2;
   localparam int XC_BUF_OVR = 1;
   localparam int XC_BUF_EN = 0;
   // coefficient table depth and width
   localparam int COEF_DEPTH = 16;
   localparam int COEF_W = 6;

   typedef enum logic [1:0] {
      RTOR_ORD_ZERO = 2'b00,
      RTOR_ORD_FIRST = 2'b01,
      RTOR_ORD_SECOND = 2'b10,
      RTOR_ORD_CASCADE = 2'b11
   } rtor_order_t;

   typedef enum logic [2:0] {
      RTOR_PW_LOW = 3'b000,
      RTOR_PW_READY = 3'b001,
      RTOR_PW_TX = 3'b010,
      RTOR_PW_TUNE = 3'b011,
      RTOR_PW_RX = 3'b111
   } rtor_pwst_t;

   // one register access from the serial port engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } rtor_req_t;

   // delta-sigma modulator controls
   typedef struct packed {
      logic dither_en;
      logic open_loop;
      logic mod_65536;
      rtor_order_t order;
      logic rst_mode;
      logic rst;
   } rtor_dsm_t;

   // crystal oscillator controls
   typedef struct packed {
      logic clk_hyst;
      logic double_bias;
      logic double_gain;
      logic out_buf_en;
   } rtor_xtal_t;
endpackage : rtor_pkg

// ===== tb/rtor_regs_tb_top.sv
// rtor_regs_tb_top: self-checking bench for the radio test override register bank
`timescale 1ns/100ps
`default_nettype none
module rtor_regs_tb_top;
   typedef struct packed {
      logic [6:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } rtor_row_t;
   logic clock_i;
   logic rst_i;
   rtor_pkg::rtor_req_t req_i;
   logic vco_type_i;
   rtor_pkg::rtor_pwst_t pwst_i;
   logic sm_buf_en_i;
   logic [7:0] rd_data_o;
   rtor_pkg::rtor_dsm_t dsm_o;
   logic [7:0] force_a_o;
   logic [7:0] force_b_o;
   logic [7:0] force_syn_o;
   logic [3:0] coef_idx_o;
   logic [5:0] coef_val_o;
   rtor_pkg::rtor_xtal_t xtal_o;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   // write then read back; reserved and read-only bits come back as the port says
   rtor_row_t rows [8] = '{'{7'h5c, 8'hff, 8'hbf}, '{7'h5d, 8'ha5, 8'ha5},
      '{7'h5e, 8'h5a, 8'h5a}, '{7'h5f, 8'hc3, 8'hc3}, '{7'h60, 8'hf7, 8'h07},
      '{7'h61, 8'hff, 8'h3f}, '{7'h62, 8'hff, 8'h7f}, '{7'h6f, 8'h55, 8'h00}};
   // reset contents; power state tune shows in the top three oscillator bits
   rtor_row_t rst_rows [7] = '{'{7'h5c, 8'h00, 8'h0e}, '{7'h5d, 8'h00, 8'h00},
      '{7'h5e, 8'h00, 8'h00}, '{7'h5f, 8'h00, 8'h00}, '{7'h60, 8'h00, 8'h00},
      '{7'h61, 8'h00, 8'h00}, '{7'h62, 8'h00, 8'h64}};

   rtor_regs dut_u (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .req_i(req_i),
      .vco_type_i(vco_type_i),
      .pwst_i(pwst_i),
      .sm_buf_en_i(sm_buf_en_i),
      .rd_data_o(rd_data_o),
      .dsm_o(dsm_o),
      .force_a_o(force_a_o),
      .force_b_o(force_b_o),
      .force_syn_o(force_syn_o),
      .coef_idx_o(coef_idx_o),
      .coef_val_o(coef_val_o),
      .xtal_o(xtal_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // one request held across exactly one rising edge, dropped at the next falling edge
   task automatic acc(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
      @(negedge clock_i);
      req_i = '{wr: w, rd: r, addr: a, wdata: d};
      @(negedge clock_i);
      req_i = '0;
   endtask : acc

   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, a, 8'h00);
      chk(rd_data_o, e);
   endtask : rdc

   // write then read in the very next cycle, no idle gap between the strobes
   task automatic wrrd(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
      @(negedge clock_i);
      req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clock_i);
      req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clock_i);
      req_i = '0;
      chk(rd_data_o, e);
   endtask : wrrd

   // reset held for n cycles, then the modulator and oscillator outputs and every register readback checked at its reset value
   task automatic rst_chk(input int n);
      rst_i = 1'b1;
      repeat (n) @(negedge clock_i);
      rst_i = 1'b0;
      chk({1'b0, dsm_o}, 8'h0e);
      chk({4'h0, xtal_o}, 8'h03);
      foreach (rst_rows[i]) rdc(rst_rows[i].a, rst_rows[i].e);
      $display("test reset done");
   endtask : rst_chk

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence; inputs change only at falling edges
   initial begin
      req_i = '0;
      vco_type_i = 1'b0;
      pwst_i = rtor_pkg::RTOR_PW_TUNE;
      sm_buf_en_i = 1'b1;
      rst_i = 1'b1;
      rst_chk(16);
      foreach (rows[i]) begin
         acc(1'b1, 1'b0, rows[i].a, rows[i].d);
         rdc(rows[i].a, rows[i].e);
      end
      $display("test row table done");
      // every modulator order, then the five single-bit controls
      for (int o = 0; o < 4; o++) begin
         acc(1'b1, 1'b0, 7'h5c, 8'(o << 2));
         chk({6'h00, dsm_o.order}, 8'(o));
      end
      acc(1'b1, 1'b0, 7'h5c, 8'h03);
      chk({1'b0, dsm_o}, 8'h03);
      acc(1'b1, 1'b0, 7'h5c, 8'hb0);
      chk({1'b0, dsm_o}, 8'h70);
      acc(1'b1, 1'b0, 7'h5c, 8'h00);
      chk({1'b0, dsm_o}, 8'h00);
      vco_type_i = 1'b1;
      rdc(7'h5c, 8'h40);
      $display("test modulator done");
      // override bits land on their outputs right after the write
      acc(1'b1, 1'b0, 7'h5d, 8'h10);
      chk(force_a_o, 8'h10);
      acc(1'b1, 1'b0, 7'h5e, 8'h41);
      chk(force_b_o, 8'h41);
      acc(1'b1, 1'b0, 7'h5f, 8'h80);
      chk(force_syn_o, 8'h80);
      // write and read in one cycle: the read sees the old contents
      acc(1'b1, 1'b1, 7'h5d, 8'h3c);
      chk(rd_data_o, 8'h10);
      rdc(7'h5d, 8'h3c);
      wrrd(7'h5d, 8'h96, 8'h96);
      $display("test overrides done");
      // two table entries, each read back through its own index
      acc(1'b1, 1'b0, 7'h60, 8'h03);
      acc(1'b1, 1'b0, 7'h61, 8'h2a);
      acc(1'b1, 1'b0, 7'h60, 8'h04);
      acc(1'b1, 1'b0, 7'h61, 8'h15);
      chk({4'h0, coef_idx_o}, 8'h04);
      acc(1'b1, 1'b0, 7'h60, 8'h03);
      rdc(7'h61, 8'h2a);
      chk({2'b00, coef_val_o}, 8'h2a);
      acc(1'b1, 1'b0, 7'h60, 8'h04);
      rdc(7'h61, 8'h15);
      acc(1'b1, 1'b0, 7'h60, 8'h0f);
      wrrd(7'h61, 8'hff, 8'h3f);
      $display("test coefficient table done");
      // buffer enable ignored until the override bit is set
      acc(1'b1, 1'b0, 7'h62, 8'h01);
      sm_buf_en_i = 1'b0;
      @(negedge clock_i);
      chk({7'h00, xtal_o.out_buf_en}, 8'h00);
      acc(1'b1, 1'b0, 7'h62, 8'h03);
      chk({7'h00, xtal_o.out_buf_en}, 8'h01);
      sm_buf_en_i = 1'b1;
      acc(1'b1, 1'b0, 7'h62, 8'h02);
      chk({7'h00, xtal_o.out_buf_en}, 8'h00);
      acc(1'b1, 1'b0, 7'h62, 8'h08);
      chk({4'h0, xtal_o}, 8'h05);
      acc(1'b1, 1'b0, 7'h62, 8'h04);
      chk({4'h0, xtal_o}, 8'h03);
      acc(1'b1, 1'b0, 7'h62, 8'h10);
      chk({4'h0, xtal_o}, 8'h09);
      acc(1'b1, 1'b0, 7'h62, 8'he0);
      rdc(7'h62, 8'h60);
      // receive state shows all three power bits set
      pwst_i = rtor_pkg::RTOR_PW_RX;
      rdc(7'h62, 8'he0);
      pwst_i = rtor_pkg::RTOR_PW_TUNE;
      $display("test oscillator done");
      // second reset in mid-run brings everything back
      vco_type_i = 1'b0;
      acc(1'b1, 1'b0, 7'h60, 8'h00);
      acc(1'b1, 1'b0, 7'h61, 8'h3f);
      rst_chk(2);
      test_done();
   end
endmodule : rtor_regs_tb_top
`default_nettype wire

// ===== verilog/rtor_regs.sv
// rtor_regs: test and override register bank with coefficient table
// How it works
// - synthesizer test bit 7 enables modulator dithering; clear means none
// - synthesizer test bit 6 reads oscillator variant, read only
// - modulus bit picks 64000 when 0, 65536 when 1
// - bits 3:2 pick modulator order zero, first, second, cascaded
// - synthesizer test bit 5 sets open-loop operation
// - first override register has eight force bits, amplifier at bit 4
// - first override register resets to all zero
// - second override register forces modulator, multiplexer and four buffers
// - second override bit 6 enables lock detector directly
// - second override bit 0 forces synthesizer loop reset
// - third override register resets zero, fractional divider at bit 7
// - coefficient index holds four-bit table address in bits 3:0
// - coefficient value shows six-bit entry at current index, upper bits reserved
// - oscillator control bits 7:5 report power state, read only
// - buffer override clear lets state machine drive the output buffer
// - buffer enable bit acts only while buffer override is set
// - oscillator control bit 3 doubles bias current
// - oscillator control bit 2 doubles amplification
// - writable low five oscillator bits reset to 00100
// - host reaches the bank through serial register access
`timescale 1ns/100ps
`default_nettype none
module rtor_regs (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire rtor_pkg::rtor_req_t req_i,
   input wire logic vco_type_i,
   input wire rtor_pkg::rtor_pwst_t pwst_i,
   input wire logic sm_buf_en_i,
   output logic [7:0] rd_data_o,
   output rtor_pkg::rtor_dsm_t dsm_o,
   output logic [7:0] force_a_o,
   output logic [7:0] force_b_o,
   output logic [7:0] force_syn_o,
   output logic [3:0] coef_idx_o,
   output logic [5:0] coef_val_o,
   output rtor_pkg::rtor_xtal_t xtal_o
);

   ////////////////////////////////////////////////////////////////////////
   // storage

   logic [7:0] syn_r;
   logic [7:0] fa_r;
   logic [7:0] fb_r;
   logic [7:0] fs_r;
   logic [3:0] idx_r;
   logic [5:0] lut_r [rtor_pkg::COEF_DEPTH];
   logic [4:0] xc_r;
   logic [7:0] rd_nxt;

   // write strobe for one offset, shared by every register
   function automatic logic wr_hit(input rtor_pkg::rtor_req_t r, input logic [6:0] off);
      wr_hit = r.wr && (r.addr == off);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////
   // writable registers, each takes the port write one edge later

   // synthesizer test; bit 6 is stored but reads back from the oscillator variant input
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         syn_r <= rtor_pkg::RST_SYN_TEST;
      end else if (wr_hit(req_i, rtor_pkg::OFF_SYN_TEST)) begin
         syn_r <= req_i.wdata;
      end
   end

   // first block override
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fa_r <= rtor_pkg::RST_FORCE_A;
      end else if (wr_hit(req_i, rtor_pkg::OFF_FORCE_A)) begin
         fa_r <= req_i.wdata;
      end
   end

   // second block override, lock detect and loop reset included
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fb_r <= rtor_pkg::RST_FORCE_B;
      end else if (wr_hit(req_i, rtor_pkg::OFF_FORCE_B)) begin
         fb_r <= req_i.wdata;
      end
   end

   // synthesizer block override
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fs_r <= rtor_pkg::RST_FORCE_SYN;
      end else if (wr_hit(req_i, rtor_pkg::OFF_FORCE_SYN)) begin
         fs_r <= req_i.wdata;
      end
   end

   // coefficient index; reserved upper bits are dropped and read zero
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         idx_r <= rtor_pkg::RST_COEF_IDX;
      end else if (wr_hit(req_i, rtor_pkg::OFF_COEF_IDX)) begin
         idx_r <= req_i.wdata[3:0];
      end
   end

   // coefficient table, written through the value register at the current index
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int i = 0; i < rtor_pkg::COEF_DEPTH; i++) begin
            lut_r[i] <= rtor_pkg::RST_COEF_VAL;
         end
      end else if (wr_hit(req_i, rtor_pkg::OFF_COEF_VAL)) begin
         lut_r[idx_r] <= req_i.wdata[5:0];
      end
   end

   // oscillator control, power state bits are not stored
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         xc_r <= rtor_pkg::RST_XTAL_CTL;
      end else if (wr_hit(req_i, rtor_pkg::OFF_XTAL_CTL)) begin
         xc_r <= req_i.wdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path: one cycle after the strobe, unmapped offsets read zero

   always_comb begin
      case (req_i.addr)
         rtor_pkg::OFF_SYN_TEST: begin
            rd_nxt = syn_r;
            rd_nxt[rtor_pkg::SYN_VCO_TYPE] = vco_type_i;
         end
         rtor_pkg::OFF_FORCE_A: rd_nxt = fa_r;
         rtor_pkg::OFF_FORCE_B: rd_nxt = fb_r;
         rtor_pkg::OFF_FORCE_SYN: rd_nxt = fs_r;
         rtor_pkg::OFF_COEF_IDX: rd_nxt = {4'h0, idx_r};
         rtor_pkg::OFF_COEF_VAL: rd_nxt = {2'h0, lut_r[idx_r]};
         rtor_pkg::OFF_XTAL_CTL: rd_nxt = {pwst_i, xc_r};
         default: rd_nxt = 8'h00;
      endcase
   end

   // holds the last answer until the next read strobe
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rd_data_o <= 8'h00;
      end else if (req_i.rd) begin
         rd_data_o <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // controls to the analog blocks

   // dithering off whenever bit 7 is clear, no other path turns it on
   assign dsm_o.dither_en = syn_r[rtor_pkg::SYN_DITHER];
   assign dsm_o.open_loop = syn_r[rtor_pkg::SYN_OPEN_LOOP];
   assign dsm_o.mod_65536 = syn_r[rtor_pkg::SYN_MODULUS];
   assign dsm_o.order = rtor_pkg::rtor_order_t'(syn_r[rtor_pkg::SYN_ORDER_LO +: 2]);
   assign dsm_o.rst_mode = syn_r[rtor_pkg::SYN_RST_MODE];
   assign dsm_o.rst = syn_r[rtor_pkg::SYN_RST];
   assign force_a_o = fa_r;
   // lock detect at bit 6 and loop reset at bit 0 need no extra enable
   assign force_b_o = fb_r;
   assign force_syn_o = fs_r;
   assign coef_idx_o = idx_r;
   assign coef_val_o = lut_r[idx_r];
   assign xtal_o.clk_hyst = xc_r[rtor_pkg::XC_HYST];
   assign xtal_o.double_bias = xc_r[rtor_pkg::XC_DOUBLE_BIAS];
   assign xtal_o.double_gain = xc_r[rtor_pkg::XC_DOUBLE_GAIN];
   // enable bit is ignored unless the override bit hands it the buffer
   assign xtal_o.out_buf_en = xc_r[rtor_pkg::XC_BUF_OVR] ?
                              xc_r[rtor_pkg::XC_BUF_EN] : sm_buf_en_i;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   chk_dither_write: assert property (
      wr_hit(req_i, rtor_pkg::OFF_SYN_TEST) |=> dsm_o.dither_en == $past(req_i.wdata[7]))
      else $error("dither enable does not follow write");
   chk_vco_type_read: assert property (
      req_i.rd && req_i.addr == rtor_pkg::OFF_SYN_TEST |=> rd_data_o[6] == $past(vco_type_i))
      else $error("oscillator variant bit wrong on read");
   chk_modulus_write: assert property (
      wr_hit(req_i, rtor_pkg::OFF_SYN_TEST) |=> dsm_o.mod_65536 == $past(req_i.wdata[4]))
      else $error("modulus select wrong");
   chk_order_write: assert property (
      wr_hit(req_i, rtor_pkg::OFF_SYN_TEST) |=> dsm_o.order == $past(req_i.wdata[3:2]))
      else $error("modulator order wrong");
   chk_open_loop_hold: assert property (
      wr_hit(req_i, rtor_pkg::OFF_SYN_TEST) ##1 !wr_hit(req_i, rtor_pkg::OFF_SYN_TEST)
      |=> dsm_o.open_loop == $past(req_i.wdata[5], 2))
      else $error("open loop lost");
   chk_force_a_reset: assert property (
      @(posedge clock_i) $fell(rst_i) |-> force_a_o == 8'h00)
      else $error("first override not clear after reset");
   chk_force_a_readback: assert property (
      wr_hit(req_i, rtor_pkg::OFF_FORCE_A) ##1 (req_i.rd && !req_i.wr &&
      req_i.addr == rtor_pkg::OFF_FORCE_A) |=> rd_data_o == $past(req_i.wdata, 2))
      else $error("first override readback wrong");
   chk_lock_reset_bits: assert property (
      wr_hit(req_i, rtor_pkg::OFF_FORCE_B) |=> force_b_o[6] == $past(req_i.wdata[6]) &&
      force_b_o[0] == $past(req_i.wdata[0]))
      else $error("lock detect or loop reset wrong");
   chk_syn_force_reset: assert property (
      @(posedge clock_i) $fell(rst_i) |-> force_syn_o == 8'h00)
      else $error("synthesizer override not clear after reset");
   chk_coef_roundtrip: assert property (
      wr_hit(req_i, rtor_pkg::OFF_COEF_VAL) ##1 (req_i.rd && !req_i.wr &&
      req_i.addr == rtor_pkg::OFF_COEF_VAL) |=> rd_data_o == {2'h0, $past(req_i.wdata[5:0], 2)})
      else $error("coefficient readback wrong");
   chk_index_upper_zero: assert property (
      req_i.rd && req_i.addr == rtor_pkg::OFF_COEF_IDX |=> rd_data_o[7:4] == 4'h0)
      else $error("index reserved bits not zero");
   chk_pwst_read: assert property (
      req_i.rd && req_i.addr == rtor_pkg::OFF_XTAL_CTL |=> rd_data_o[7:5] == $past(pwst_i))
      else $error("power state bits wrong");
   chk_buf_state_machine: assert property (
      !xc_r[1] |-> xtal_o.out_buf_en == sm_buf_en_i)
      else $error("buffer not under state machine");
   chk_buf_enable_only: assert property (
      wr_hit(req_i, rtor_pkg::OFF_XTAL_CTL) && req_i.wdata[1] |=> xtal_o.out_buf_en ==
      $past(req_i.wdata[0]))
      else $error("buffer enable override wrong");
   chk_double_bits: assert property (
      wr_hit(req_i, rtor_pkg::OFF_XTAL_CTL) |=> xtal_o.double_bias == $past(req_i.wdata[3]) &&
      xtal_o.double_gain == $past(req_i.wdata[2]))
      else $error("doubling bits wrong");
   chk_xtal_reset: assert property (
      @(posedge clock_i) $fell(rst_i) |-> xc_r == 5'b00100)
      else $error("oscillator control reset wrong");

   cov_cascade_order: cover property (dsm_o.order == rtor_pkg::RTOR_ORD_CASCADE);
   cov_buf_override: cover property (xc_r[1] && xc_r[0] && !sm_buf_en_i);
   cov_coef_read: cover property (req_i.rd && req_i.addr == rtor_pkg::OFF_COEF_VAL && idx_r == 4'hf);
   cov_rx_state: cover property (req_i.rd && req_i.addr == rtor_pkg::OFF_XTAL_CTL &&
      pwst_i == rtor_pkg::RTOR_PW_RX);

endmodule : rtor_regs
`default_nettype wire
